/* cb_defs.svh */
// constants for the card-side address/data/parity datapath
// included by the package and by the bridge and card design files
`ifndef CB_DEFS_SVH
`define CB_DEFS_SVH
`define CB_ADW 32
`define CB_BEW 4
`define CB_BYTE 8
`define CB_LENW 5
`define CB_WLW 6
`define CB_FIFO_DEPTH 32
`define CB_MEM_DEPTH 32
`define CB_IDX_LO 2
`define CB_IDX_W 5
`define CB_CMD_WR_BIT 0
`define CB_SOCKETS 2
`define CB_ONE_IDX 5'h1
`define CB_ONE_WL 6'h01
`endif

/* cb_pkg.sv */
// types shared by both ends of the card-side link
// assumes cb_defs.svh is on the include path
`include "cb_defs.svh"
package cb_pkg;
    typedef struct packed {
        logic [`CB_ADW-1:0] ad;
        logic [`CB_BEW-1:0] cbe_n;
        logic par;
        logic frame_n;
        logic irdy_n;
        logic trdy_n;
    } lines_s;
    typedef enum logic [1:0] {
        I_IDLE = 2'h0,
        I_ADDR = 2'h1,
        I_DATA = 2'h3,
        I_REL = 2'h2
    } init_e;
    typedef enum logic [1:0] {
        T_IDLE = 2'h0,
        T_WAIT = 2'h1,
        T_DATA = 2'h3,
        T_REL = 2'h2
    } tgt_e;
endpackage : cb_pkg

/* cb_link_if.sv */
// shared link between the socket end and the card end
// resolves every line from both ends' enables; undriven lines pull high
`timescale 1ns/100ps
interface cb_link_if;
    logic cclk;
    cb_pkg::lines_s b_o;
    cb_pkg::lines_s b_oe;
    cb_pkg::lines_s c_o;
    cb_pkg::lines_s c_oe;
    cb_pkg::lines_s line;
    genvar g;
    for (g = 0; g < $bits(cb_pkg::lines_s); g++) begin : g_res
        assign line[g] = b_oe[g] ? b_o[g] : (c_oe[g] ? c_o[g] : 1'b1);
    end
    modport bridge (output cclk, output b_o, output b_oe, input line);
    modport card (input cclk, output c_o, output c_oe, input line);
endinterface : cb_link_if

/* cb_bridge.sv */
// socket end: per-socket datapath engine, write FIFO, two-socket top
// assumes a card end on each link; only one side starts a transaction at a time
//
// Behaviour
// - one address phase, then one or more data phases
// - full 32-bit address in first framed cycle
// - I/O byte address; memory/config dword address
// - byte 0 on bits 7:0, byte 3 on 31:24
// - data stable whenever its ready is asserted
// - word moves only when both readies asserted
// - read and write bursts supported
// - command on command lines during address phase
// - byte enables held whole data phase
// - enable line n qualifies byte lane n
// - even parity over address, command, parity
// - address parity one clock after address
// - data parity one clock after ready
// - parity held one clock past phase end
// - initiator: address/write parity; target: read parity
// - link sampled on rising link clock edge
// - frame starts address; released frame marks last
`timescale 1ns/100ps
`include "cb_defs.svh"

////////////////////////////////////////////////////////////////////////////////
module cb_fifo #(
    parameter int WIDTH = `CB_ADW,
    parameter int DEPTH = `CB_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem[rd_q];
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= push ? AW'(wr_q + 1'b1) : wr_q;
            rd_q <= pop ? AW'(rd_q + 1'b1) : rd_q;
            cnt_q <= (AW+1)'(cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
        end
    end
endmodule : cb_fifo

////////////////////////////////////////////////////////////////////////////////
// one datapath: initiator, target with a small word store, parity
// link flops move only on step: the link's rising edge at the card end, its falling edge at the socket end
module cb_engine (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic step,
    // link
    input wire cb_pkg::lines_s line_i,
    output cb_pkg::lines_s line_o,
    output cb_pkg::lines_s line_oe,
    // request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [`CB_BEW-1:0] req_cmd,
    input wire logic [`CB_ADW-1:0] req_addr,
    input wire logic [`CB_LENW-1:0] req_len,
    input wire logic [`CB_BEW-1:0] req_be_n,
    // write data
    input wire logic wd_valid,
    output logic wd_ready,
    input wire logic [`CB_ADW-1:0] wd_data,
    input wire logic [`CB_BEW-1:0] wd_be_n,
    // answers
    output logic rd_valid,
    output logic [`CB_ADW-1:0] rd_data,
    output logic done
);
    cb_pkg::init_e ist_q;
    cb_pkg::tgt_e tst_q;
    logic [`CB_ADW-1:0] io_q, tad_q;
    logic [`CB_BEW-1:0] cbe_q, be_q;
    logic [`CB_WLW-1:0] wl_q;
    logic [`CB_IDX_W-1:0] idx_q;
    logic i_oe_q, i_adoe_q, wr_q, frame_n_q, irdy_n_q;
    logic twr_q, tad_oe_q, trdy_n_q, trdy_oe_q, fr_prev_q, par_q, par_oe_q;
    logic rd_valid_q, done_q;
    logic [`CB_ADW-1:0] rd_data_q;
    logic f_valid;
    logic [`CB_ADW-1:0] f_data;
    logic [`CB_BEW-1:0] f_be_n;
    logic [`CB_ADW-1:0] t_word;
    logic i_pop;

    // a pending write word that is not yet in the FIFO stalls irdy
    cb_fifo #(.WIDTH(`CB_ADW + `CB_BEW), .DEPTH(`CB_FIFO_DEPTH)) u_wfifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(wd_valid),
        .in_ready(wd_ready),
        .in_data({wd_data, wd_be_n}),
        .out_valid(f_valid),
        .out_ready(i_pop),
        .out_data({f_data, f_be_n})
    );

    ////////////////////////////////////////////////////////////////////////////
    wire bus_idle = line_i.frame_n && line_i.irdy_n;
    wire i_take = step && (ist_q == cb_pkg::I_IDLE) && (tst_q == cb_pkg::T_IDLE) && bus_idle;
    wire i_xfer = (ist_q == cb_pkg::I_DATA) && !irdy_n_q && !line_i.trdy_n;
    wire i_slot = (ist_q == cb_pkg::I_ADDR) || ((ist_q == cb_pkg::I_DATA) && (irdy_n_q || i_xfer));
    wire i_load = i_slot && (wl_q != '0) && (!wr_q || f_valid);
    assign i_pop = step && i_load && wr_q;
    wire i_fin = i_xfer && (wl_q == '0);
    wire t_start = (ist_q == cb_pkg::I_IDLE) && fr_prev_q && !line_i.frame_n;
    wire t_xfer = (tst_q == cb_pkg::T_DATA) && !trdy_n_q && !line_i.irdy_n;
    wire [`CB_IDX_W-1:0] t_ridx = (tst_q == cb_pkg::T_DATA) ? idx_q + `CB_ONE_IDX : idx_q;
    assign req_ready = i_take;

    // byte lanes of the target store, one per enable line
    genvar g;
    for (g = 0; g < `CB_BEW; g++) begin : g_lane
        logic [`CB_BYTE-1:0] mem_b [`CB_MEM_DEPTH];
        always_ff @(posedge clk) begin
            if (step && t_xfer && twr_q && !line_i.cbe_n[g]) begin
                mem_b[idx_q] <= line_i.ad[g*`CB_BYTE +: `CB_BYTE];
            end
        end
        assign t_word[g*`CB_BYTE +: `CB_BYTE] = mem_b[t_ridx];
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ist_q <= cb_pkg::I_IDLE;
            io_q <= '0;
            cbe_q <= '0;
            be_q <= '0;
            wl_q <= '0;
            i_oe_q <= 1'b0;
            i_adoe_q <= 1'b0;
            wr_q <= 1'b0;
            frame_n_q <= 1'b1;
            irdy_n_q <= 1'b1;
        end else if (step) begin
            case (ist_q)
                cb_pkg::I_IDLE: begin
                    if (i_take && req_valid) begin
                        ist_q <= cb_pkg::I_ADDR;
                        io_q <= req_addr;
                        cbe_q <= req_cmd;
                        be_q <= req_be_n;
                        wr_q <= req_cmd[`CB_CMD_WR_BIT];
                        wl_q <= `CB_WLW'(req_len) + `CB_ONE_WL;
                        frame_n_q <= 1'b0;
                        i_oe_q <= 1'b1;
                        i_adoe_q <= 1'b1;
                    end
                end
                cb_pkg::I_ADDR, cb_pkg::I_DATA: begin
                    ist_q <= cb_pkg::I_DATA;
                    i_adoe_q <= wr_q;
                    if (i_load) begin
                        io_q <= wr_q ? f_data : io_q;
                        cbe_q <= wr_q ? f_be_n : be_q;
                        irdy_n_q <= 1'b0;
                        wl_q <= wl_q - `CB_ONE_WL;
                        frame_n_q <= (wl_q == `CB_ONE_WL);
                    end else if (i_slot) begin
                        irdy_n_q <= 1'b1;
                    end
                    if (i_fin) begin
                        ist_q <= cb_pkg::I_REL;
                        irdy_n_q <= 1'b1;
                        i_adoe_q <= 1'b0;
                    end
                end
                default: begin
                    ist_q <= cb_pkg::I_IDLE;
                    i_oe_q <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tst_q <= cb_pkg::T_IDLE;
            idx_q <= '0;
            twr_q <= 1'b0;
            tad_q <= '0;
            tad_oe_q <= 1'b0;
            trdy_n_q <= 1'b1;
            trdy_oe_q <= 1'b0;
            fr_prev_q <= 1'b1;
        end else if (step) begin
            fr_prev_q <= line_i.frame_n;
            case (tst_q)
                cb_pkg::T_IDLE: begin
                    if (t_start) begin
                        tst_q <= cb_pkg::T_WAIT;
                        // I/O low bits only name a lane; store is word indexed
                        idx_q <= line_i.ad[`CB_IDX_LO +: `CB_IDX_W];
                        twr_q <= line_i.cbe_n[`CB_CMD_WR_BIT];
                        trdy_oe_q <= 1'b1;
                    end
                end
                // one idle turn so the initiator lets go of the lines first
                cb_pkg::T_WAIT: begin
                    tst_q <= cb_pkg::T_DATA;
                    trdy_n_q <= 1'b0;
                    tad_q <= t_word;
                    tad_oe_q <= !twr_q;
                end
                cb_pkg::T_DATA: begin
                    if (t_xfer) begin
                        idx_q <= t_ridx;
                        tad_q <= t_word;
                        if (line_i.frame_n) begin
                            tst_q <= cb_pkg::T_REL;
                            trdy_n_q <= 1'b1;
                            tad_oe_q <= 1'b0;
                        end
                    end
                end
                default: begin
                    tst_q <= cb_pkg::T_IDLE;
                    trdy_oe_q <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // parity covers the lines as seen one link clock earlier
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            par_q <= 1'b0;
            par_oe_q <= 1'b0;
        end else if (step) begin
            par_q <= ^{line_i.ad, line_i.cbe_n};
            par_oe_q <= i_adoe_q || tad_oe_q;
        end
    end

    // answers are one clk cycle wide: one CLK at the socket end, one link clock at the card end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_valid_q <= 1'b0;
            rd_data_q <= '0;
            done_q <= 1'b0;
        end else begin
            rd_valid_q <= step && i_xfer && !wr_q;
            rd_data_q <= (step && i_xfer && !wr_q) ? line_i.ad : rd_data_q;
            done_q <= step && (ist_q == cb_pkg::I_REL);
        end
    end
    assign rd_valid = rd_valid_q;
    assign rd_data = rd_data_q;
    assign done = done_q;

    assign line_o.ad = i_adoe_q ? io_q : tad_q;
    assign line_o.cbe_n = cbe_q;
    assign line_o.par = par_q;
    assign line_o.frame_n = frame_n_q;
    assign line_o.irdy_n = irdy_n_q;
    assign line_o.trdy_n = trdy_n_q;
    assign line_oe.ad = {`CB_ADW{i_adoe_q || tad_oe_q}};
    assign line_oe.cbe_n = {`CB_BEW{i_oe_q}};
    assign line_oe.par = par_oe_q;
    assign line_oe.frame_n = i_oe_q;
    assign line_oe.irdy_n = i_oe_q;
    assign line_oe.trdy_n = trdy_oe_q;
endmodule : cb_engine

////////////////////////////////////////////////////////////////////////////////
// two sockets, one link clock made by halving CLK
module cb_bridge (
    // clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // links
    cb_link_if.bridge SOCK_A,
    cb_link_if.bridge SOCK_B,
    // requests, index 0 is socket A
    input wire logic [`CB_SOCKETS-1:0] REQ_VALID,
    output logic [`CB_SOCKETS-1:0] REQ_READY,
    input wire logic [`CB_SOCKETS-1:0][`CB_BEW-1:0] REQ_CMD,
    input wire logic [`CB_SOCKETS-1:0][`CB_ADW-1:0] REQ_ADDR,
    input wire logic [`CB_SOCKETS-1:0][`CB_LENW-1:0] REQ_LEN,
    input wire logic [`CB_SOCKETS-1:0][`CB_BEW-1:0] REQ_BE_N,
    // write data
    input wire logic [`CB_SOCKETS-1:0] WD_VALID,
    output logic [`CB_SOCKETS-1:0] WD_READY,
    input wire logic [`CB_SOCKETS-1:0][`CB_ADW-1:0] WD_DATA,
    input wire logic [`CB_SOCKETS-1:0][`CB_BEW-1:0] WD_BE_N,
    // answers
    output logic [`CB_SOCKETS-1:0] RD_VALID,
    output logic [`CB_SOCKETS-1:0][`CB_ADW-1:0] RD_DATA,
    output logic [`CB_SOCKETS-1:0] DONE
);
    logic cclk_q;
    cb_pkg::lines_s li [`CB_SOCKETS];
    cb_pkg::lines_s lo [`CB_SOCKETS];
    cb_pkg::lines_s loe [`CB_SOCKETS];
    // our side moves where the link clock falls, half a period from the card
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cclk_q <= 1'b0;
        end else begin
            cclk_q <= !cclk_q;
        end
    end
    assign SOCK_A.cclk = cclk_q;
    assign SOCK_B.cclk = cclk_q;
    assign li[0] = SOCK_A.line;
    assign li[1] = SOCK_B.line;
    assign SOCK_A.b_o = lo[0];
    assign SOCK_A.b_oe = loe[0];
    assign SOCK_B.b_o = lo[1];
    assign SOCK_B.b_oe = loe[1];
    genvar s;
    for (s = 0; s < `CB_SOCKETS; s++) begin : g_sock
        cb_pkg::lines_s lq;
        // the card launches after the rising edge; keep what stood just before it
        always_ff @(posedge CLK or negedge ARST_N) begin
            if (!ARST_N) begin
                lq <= '1;
            end else if (!cclk_q) begin
                lq <= li[s];
            end
        end
        cb_engine u_eng (
            .clk(CLK),
            .rst_n(ARST_N),
            .step(cclk_q),
            .line_i(lq),
            .line_o(lo[s]),
            .line_oe(loe[s]),
            .req_valid(REQ_VALID[s]),
            .req_ready(REQ_READY[s]),
            .req_cmd(REQ_CMD[s]),
            .req_addr(REQ_ADDR[s]),
            .req_len(REQ_LEN[s]),
            .req_be_n(REQ_BE_N[s]),
            .wd_valid(WD_VALID[s]),
            .wd_ready(WD_READY[s]),
            .wd_data(WD_DATA[s]),
            .wd_be_n(WD_BE_N[s]),
            .rd_valid(RD_VALID[s]),
            .rd_data(RD_DATA[s]),
            .done(DONE[s])
        );
    end
endmodule : cb_bridge

/* cb_card.sv */
// card end: same datapath engine, run on the link's own clock
// assumes cb_bridge.sv (engine, FIFO) and cb_link_if.sv are compiled first
`timescale 1ns/100ps
`include "cb_defs.svh"

////////////////////////////////////////////////////////////////////////////////
module cb_card (
    // reset, released on the link clock
    input wire logic ARST_N,
    // link
    cb_link_if.card LINK,
    // requests, timed by LINK.cclk
    input wire logic REQ_VALID,
    output logic REQ_READY,
    input wire logic [`CB_BEW-1:0] REQ_CMD,
    input wire logic [`CB_ADW-1:0] REQ_ADDR,
    input wire logic [`CB_LENW-1:0] REQ_LEN,
    input wire logic [`CB_BEW-1:0] REQ_BE_N,
    // write data
    input wire logic WD_VALID,
    output logic WD_READY,
    input wire logic [`CB_ADW-1:0] WD_DATA,
    input wire logic [`CB_BEW-1:0] WD_BE_N,
    // answers
    output logic RD_VALID,
    output logic [`CB_ADW-1:0] RD_DATA,
    output logic DONE
);
    logic rs1_q, rs2_q;
    // assert at once, release in step with the link clock
    always_ff @(posedge LINK.cclk or negedge ARST_N) begin
        if (!ARST_N) begin
            rs1_q <= 1'b0;
            rs2_q <= 1'b0;
        end else begin
            rs1_q <= 1'b1;
            rs2_q <= rs1_q;
        end
    end
    // every rising link edge is a bus sample point
    cb_engine u_eng (
        .clk(LINK.cclk),
        .rst_n(rs2_q),
        .step(1'b1),
        .line_i(LINK.line),
        .line_o(LINK.c_o),
        .line_oe(LINK.c_oe),
        .req_valid(REQ_VALID),
        .req_ready(REQ_READY),
        .req_cmd(REQ_CMD),
        .req_addr(REQ_ADDR),
        .req_len(REQ_LEN),
        .req_be_n(REQ_BE_N),
        .wd_valid(WD_VALID),
        .wd_ready(WD_READY),
        .wd_data(WD_DATA),
        .wd_be_n(WD_BE_N),
        .rd_valid(RD_VALID),
        .rd_data(RD_DATA),
        .done(DONE)
    );
endmodule : cb_card

/* cb_link_asserts.sv */
// assertions on one link between the socket end and a card end
// assumes the link resolves both ends' drives; sees wire and enables only
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
module cb_link_asserts (
    // link clock and reset
    input wire logic cclk,
    input wire logic ARST_N,
    // resolved lines and drive enables
    input wire cb_pkg::lines_s line,
    input wire cb_pkg::lines_s b_oe,
    input wire cb_pkg::lines_s c_oe
);
    default clocking @(posedge cclk); endclocking
    default disable iff (!ARST_N);

    logic wr_q;
    logic binit_q;
    // bridge owns data parity when it writes as initiator or answers a read
    wire bpar = wr_q == binit_q;

    always_ff @(posedge cclk or negedge ARST_N) begin
        if (!ARST_N) begin
            wr_q <= 1'b0;
            binit_q <= 1'b0;
        end else if ($fell(line.frame_n)) begin
            wr_q <= line.cbe_n[0];
            binit_q <= b_oe.frame_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    sequence s_addr;
        $fell(line.frame_n);
    endsequence
    sequence s_xfer;
        !line.irdy_n && !line.trdy_n;
    endsequence

    a_addr_no_ready: assert property (s_addr |-> line.irdy_n && line.trdy_n)
        else $error("ready asserted in address phase");
    a_addr_parity: assert property (s_addr |=> line.par == ^$past({line.ad, line.cbe_n}))
        else $error("address parity wrong or late");
    a_data_follows: assert property (s_addr |-> ##[1:80] s_xfer)
        else $error("no data phase after address");
    a_data_parity: assert property (s_xfer |=> line.par == ^$past({line.ad, line.cbe_n}))
        else $error("data parity wrong or late");
    a_par_held: assert property (s_xfer |=> b_oe.par || c_oe.par)
        else $error("parity released too early");
    a_par_owner: assert property (s_xfer |=> b_oe.par == bpar && c_oe.par == !bpar)
        else $error("parity driven by wrong side");
    a_write_stable: assert property (!line.irdy_n && line.trdy_n && wr_q
        |=> $stable(line.ad) && $stable(line.cbe_n))
        else $error("write data or enables moved in wait state");
    a_last_release: assert property ((s_xfer and line.frame_n) |=> line.irdy_n)
        else $error("ready held after final data phase");
    a_no_contention: assert property (!(|(b_oe & c_oe)))
        else $error("both ends drive one line");
endmodule : cb_link_asserts

/* cardbus_addr_data_parity_tb_top.sv */
// bench: socket end joined to a card end on each of two links
// assumes the socket end makes the link clock and both card ends run on it
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
module cardbus_addr_data_parity_tb_top;
    typedef struct packed {
        logic s;
        logic [3:0] cmd;
        logic [31:0] addr;
        logic [4:0] len;
        logic [31:0] base;
    } row_s;
    // s=1: card on the second link starts and the socket end answers
    localparam row_s ROWS [6] = '{
        '{1'b0, 4'h3, 32'h0000_0012, 5'h00, 32'h1111_0000},
        '{1'b0, 4'h7, 32'h0000_0040, 5'h03, 32'hA5A5_0000},
        '{1'b0, 4'hB, 32'h0000_0008, 5'h01, 32'hC3C3_0000},
        '{1'b0, 4'h7, 32'h0000_0000, 5'h1F, 32'h7700_0000},
        '{1'b1, 4'h7, 32'h0000_0020, 5'h02, 32'h5A5A_0000},
        '{1'b1, 4'h3, 32'h0000_0013, 5'h00, 32'h0F0F_0000}};
    logic CLK = 1'b0;
    logic ARST_N = 1'b0;
    logic [1:0] bq_valid = '0;
    logic [1:0] cq_valid = '0;
    logic [1:0] bw_valid = '0;
    logic [1:0] cw_valid = '0;
    logic [1:0][3:0] cmd = '0;
    logic [1:0][31:0] addr = '0;
    logic [1:0][4:0] len = '0;
    logic [1:0][31:0] wdat = '0;
    logic [1:0][3:0] be_n = '0;
    wire logic [1:0] b_rrdy, b_wrdy, b_rv, b_done, c_rrdy, c_wrdy, c_rv, c_done;
    wire logic [1:0][31:0] b_rd, c_rd;
    int fails = 0;
    int tests_run = 0;
    logic [31:0] rq [2][$];
    logic [1:0] fprev = '1;
    logic [1:0] got = '0;
    logic [1:0][31:0] sad, sdat;
    logic [1:0][3:0] scmd;

    always #20 CLK = ~CLK;

    cb_link_if i_cb_link_if [2] ();
    cb_bridge i_cb_bridge (.CLK(CLK), .ARST_N(ARST_N), .SOCK_A(i_cb_link_if[0]),
        .SOCK_B(i_cb_link_if[1]), .REQ_VALID(bq_valid), .REQ_READY(b_rrdy), .REQ_CMD(cmd),
        .REQ_ADDR(addr), .REQ_LEN(len), .REQ_BE_N(be_n), .WD_VALID(bw_valid),
        .WD_READY(b_wrdy), .WD_DATA(wdat), .WD_BE_N(be_n), .RD_VALID(b_rv),
        .RD_DATA(b_rd), .DONE(b_done));
    cb_link_asserts i_cb_link_asserts (.cclk(i_cb_link_if[0].cclk), .ARST_N(ARST_N),
        .line(i_cb_link_if[0].line), .b_oe(i_cb_link_if[0].b_oe), .c_oe(i_cb_link_if[0].c_oe));

    for (genvar g = 0; g < 2; g++) begin : g_card
        cb_card i_cb_card (.ARST_N(ARST_N), .LINK(i_cb_link_if[g]), .REQ_VALID(cq_valid[g]),
            .REQ_READY(c_rrdy[g]), .REQ_CMD(cmd[g]), .REQ_ADDR(addr[g]), .REQ_LEN(len[g]),
            .REQ_BE_N(be_n[g]), .WD_VALID(cw_valid[g]), .WD_READY(c_wrdy[g]),
            .WD_DATA(wdat[g]), .WD_BE_N(be_n[g]), .RD_VALID(c_rv[g]), .RD_DATA(c_rd[g]),
            .DONE(c_done[g]));
        // sample while cclk is low: both ends hold the lines then
        always @(negedge CLK) if (i_cb_link_if[g].cclk === 1'b0) mon(i_cb_link_if[g].line, g);
    end

    always @(negedge CLK) if (b_rv[0] === 1'b1) rq[0].push_back(b_rd[0]);
    always @(negedge i_cb_link_if[1].cclk) if (c_rv[1] === 1'b1) rq[1].push_back(c_rd[1]);

    ////////////////////////////////////////////////////////////////////////////
    task automatic mon(input cb_pkg::lines_s l, input int i);
        if (fprev[i] && !l.frame_n) begin
            sad[i] = l.ad;
            scmd[i] = l.cbe_n;
            got[i] = 1'b0;
        end
        if (!got[i] && !l.irdy_n && !l.trdy_n) begin
            sdat[i] = l.ad;
            got[i] = 1'b1;
        end
        fprev[i] = l.frame_n;
    endtask : mon

    task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tick(input int s);
        if (s) @(negedge i_cb_link_if[1].cclk);
        else @(negedge CLK);
    endtask : tick

    task automatic push(input int s, input logic [31:0] d);
        tick(s);
        wdat[s] = d;
        if (s) cw_valid[1] = 1'b1;
        else bw_valid[0] = 1'b1;
        tick(s);
        cw_valid = '0;
        bw_valid = '0;
    endtask : push

    task automatic start(input row_s r, input logic wr);
        int n;
        n = 0;
        tick(r.s);
        cmd[r.s] = {r.cmd[3:1], wr};
        addr[r.s] = r.addr;
        len[r.s] = r.len;
        if (r.s) cq_valid[1] = 1'b1;
        else bq_valid[0] = 1'b1;
        while ((r.s ? c_rrdy[1] : b_rrdy[0]) !== 1'b1 && n < 500) begin
            tick(r.s);
            n++;
        end
        tick(r.s);
        cq_valid = '0;
        bq_valid = '0;
        while ((r.s ? c_done[1] : b_done[0]) !== 1'b1 && n < 1000) begin
            tick(r.s);
            n++;
        end
        check("handshake", n < 1000, 1'b1);
    endtask : start

    task automatic run(input row_s r);
        for (int i = 0; i <= r.len; i++) push(r.s, r.base + i);
        if (r.len == 5'h1F) begin
            tick(0);
            check("fifo full", b_wrdy[0], 1'b0);
        end
        start(r, 1'b1);
        check("address", sad[r.s], r.addr);
        check("command", scmd[r.s], {r.cmd[3:1], 1'b1});
        check("lane order", sdat[r.s], r.base);
        start(r, 1'b0);
        check("read command", scmd[r.s], {r.cmd[3:1], 1'b0});
        check("word count", rq[r.s].size(), r.len + 1);
        for (int i = 0; rq[r.s].size() > 0; i++) check("read data", rq[r.s].pop_front(), r.base + i);
    endtask : run

    task automatic finish_test();
        if (fails == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : finish_test

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #400_000;
        fails++;
        finish_test();
    end

    initial begin
        repeat (4) @(posedge CLK);
        check("idle lines", i_cb_link_if[0].line, '1);
        check("done in reset", b_done, 2'b00);
        @(negedge CLK) ARST_N = 1'b1;
        repeat (10) @(negedge CLK);
        foreach (ROWS[k]) run(ROWS[k]);
        // stale words left in the fifo must not survive a reset
        push(0, 32'hDEAD_0000);
        push(0, 32'hDEAD_0001);
        @(negedge CLK) ARST_N = 1'b0;
        repeat (4) @(negedge CLK);
        ARST_N = 1'b1;
        repeat (10) @(negedge CLK);
        run('{1'b0, 4'h7, 32'h0000_0030, 5'h01, 32'h2468_0000});
        // partial enables: only lanes 0 and 2 may change
        be_n[0] = 4'hA;
        push(0, 32'h1234_5678);
        start('{1'b0, 4'h7, 32'h0000_0030, 5'h00, 32'h0000_0000}, 1'b1);
        be_n[0] = 4'h0;
        start('{1'b0, 4'h7, 32'h0000_0030, 5'h00, 32'h0000_0000}, 1'b0);
        check("byte enables", rq[0].pop_front(), 32'h2434_0078);
        finish_test();
    end
endmodule : cardbus_addr_data_parity_tb_top
